// ### core/spcs_pkg.sv
// Contract
// - order bit 0 shifts LSB first, 1 MSB first
// - edge bit picks launch/capture edge per polarity
// - data write during transfer sets collision flag
// - colliding data write is discarded entirely
// - completed word sets the complete flag
// - complete flag can raise an interrupt request
// - select enable 0 floats the select pin
// - polarity 1 idles clock low, 0 high
// - enabled master starts on data write
package spcs_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] SPCS_OFF_CTRL = 8'h00;
    localparam logic [7:0] SPCS_OFF_STAT = 8'h04;
    localparam logic [7:0] SPCS_OFF_DATA = 8'h08;

    localparam int SPCS_CTRL_EN    = 0;
    localparam int SPCS_CTRL_ORDER = 1;
    localparam int SPCS_CTRL_SELEN = 2;
    localparam int SPCS_CTRL_POL   = 3;
    localparam int SPCS_CTRL_EDGE  = 4;
    localparam int SPCS_CTRL_W     = 5;

    localparam int SPCS_STAT_TCF  = 0;
    localparam int SPCS_STAT_WRITE_COLLISION_FLAG = 1;
    localparam int SPCS_STAT_BUSY = 2;

    localparam logic [4:0] SPCS_CTRL_RST = 5'h00;
    localparam int         SPCS_WORD_W   = 8;

    // ****************************************
    // clock generator state
    // ****************************************
    typedef enum logic {
        SPCS_GEN_IDLE  = 1'b0,
        SPCS_GEN_SHIFT = 1'b1
    } spcs_gen_t;
endpackage : spcs_pkg

// ### core/spcs_edge_if.sv
`timescale 1ns/1ps
interface spcs_edge_if;
    logic start;
    logic idle_level;
    logic sck;
    logic lead;
    logic trail;
    logic last;
    logic active;

    modport gen (
        input  start,
        input  idle_level,
        output sck,
        output lead,
        output trail,
        output last,
        output active
    );
    modport eng (
        output start,
        output idle_level,
        input  sck,
        input  lead,
        input  trail,
        input  last,
        input  active
    );
endinterface : spcs_edge_if

// ### core/spcs_sync.sv
`timescale 1ns/1ps
module spcs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : spcs_sync

// ### core/spcs_clkgen.sv
`timescale 1ns/1ps
module spcs_clkgen
    import spcs_pkg::*;
#(
    parameter int W = SPCS_WORD_W
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    spcs_edge_if.gen   eif
);
    localparam int CW = $clog2(2 * W);
    localparam logic [CW-1:0] LAST_H = CW'(2 * W - 1);

    spcs_gen_t      state_ff;
    logic [CW-1:0]  half_ff;
    logic           sck_ff;

    // one half period of the serial clock per link clock cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SPCS_GEN_IDLE;
            half_ff  <= '0;
            sck_ff   <= 1'b1;
        end else begin
            case (state_ff)
                SPCS_GEN_IDLE: begin
                    sck_ff  <= eif.idle_level;
                    half_ff <= '0;
                    if (eif.start) begin
                        state_ff <= SPCS_GEN_SHIFT;
                    end
                end
                SPCS_GEN_SHIFT: begin
                    sck_ff  <= ~sck_ff;
                    half_ff <= half_ff + CW'(1);
                    if (half_ff == LAST_H) begin
                        state_ff <= SPCS_GEN_IDLE;
                    end
                end
                default: state_ff <= SPCS_GEN_IDLE;
            endcase
        end
    end

    assign eif.sck    = sck_ff;
    assign eif.active = (state_ff == SPCS_GEN_SHIFT);
    assign eif.lead   = eif.active & ~half_ff[0];
    assign eif.trail  = eif.active & half_ff[0];
    assign eif.last   = eif.active & (half_ff == LAST_H);
endmodule : spcs_clkgen

// ### core/spcs_top.sv
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module spcs_top
    import spcs_pkg::*;
#(
    parameter int W = SPCS_WORD_W
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        link_clk,
    output logic             sck_o,
    output logic             mosi_o,
    output logic             bus_oe_o,
    input  wire logic        miso_i,
    output logic             select_line_n_o,
    output logic             select_line_n_oe,
    output logic             xfer_irq
);
    // ****************************************
    // parameter check
    // ****************************************
    if (W < 2 || W > 32) begin : g_bad_width
        $error("word width must be 2 to 32");
    end

    function automatic logic [W-1:0] rev_bits(input logic [W-1:0] v);
        logic [W-1:0] r;
        r = '0;
        for (int i = 0; i < W; i++) begin
            r[i] = v[W-1-i];
        end
        return r;
    endfunction : rev_bits

    // ****************************************
    // bus slave, zero wait states
    // ****************************************
    logic            dp_valid_ff;
    logic            dp_write_ff;
    logic [7:0]      dp_addr_ff;
    logic [31:0]     hrdata_ff;
    logic [31:0]     nxt_hrdata;
    logic [SPCS_CTRL_W-1:0] ctrl_ff;
    logic            tcf_ff;
    logic            write_collision_flag_ff;
    logic            busy_ff;
    logic [W-1:0]    tx_word_ff;
    logic [W-1:0]    rx_word_ff;
    logic            start_tgl_ff;
    logic            xfer_irq_ff;
    logic            done_seen;

    wire ap_take = hsel & hready & htrans[1];
    wire wr_ctrl = dp_valid_ff & dp_write_ff & (dp_addr_ff == SPCS_OFF_CTRL);
    wire wr_stat = dp_valid_ff & dp_write_ff & (dp_addr_ff == SPCS_OFF_STAT);
    wire wr_data = dp_valid_ff & dp_write_ff & (dp_addr_ff == SPCS_OFF_DATA);
    wire do_start   = wr_data & ~busy_ff & ctrl_ff[SPCS_CTRL_EN];
    wire do_collide = wr_data & busy_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_addr_ff  <= 8'h00;
        end else begin
            dp_valid_ff <= ap_take;
            dp_write_ff <= hwrite;
            dp_addr_ff  <= haddr[7:0];
        end
    end

    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        case (haddr[7:0])
            SPCS_OFF_CTRL: nxt_hrdata[SPCS_CTRL_W-1:0] = ctrl_ff;
            SPCS_OFF_STAT: begin
                nxt_hrdata[SPCS_STAT_TCF]  = tcf_ff;
                nxt_hrdata[SPCS_STAT_WRITE_COLLISION_FLAG] = write_collision_flag_ff;
                nxt_hrdata[SPCS_STAT_BUSY] = busy_ff;
            end
            SPCS_OFF_DATA: nxt_hrdata[W-1:0] = rx_word_ff;
            default:       nxt_hrdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    // ****************************************
    // control and status
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= SPCS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= hwdata[SPCS_CTRL_W-1:0];
        end
    end

    // flags: writing 0 clears, hardware set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            write_collision_flag_ff <= 1'b0;
        end else if (do_collide) begin
            write_collision_flag_ff <= 1'b1;
        end else if (wr_stat && !hwdata[SPCS_STAT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcf_ff <= 1'b0;
        end else if (done_seen) begin
            tcf_ff <= 1'b1;
        end else if (wr_stat && !hwdata[SPCS_STAT_TCF]) begin
            tcf_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_irq_ff <= 1'b0;
        end else begin
            xfer_irq_ff <= tcf_ff;
        end
    end
    assign xfer_irq = xfer_irq_ff;

    // word held stable while busy; link side reads it then
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_word_ff   <= '0;
            start_tgl_ff <= 1'b0;
            busy_ff      <= 1'b0;
        end else begin
            if (do_start) begin
                tx_word_ff   <= hwdata[W-1:0];
                start_tgl_ff <= ~start_tgl_ff;
                busy_ff      <= 1'b1;
            end else if (done_seen) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // completion crossing into bus clock
    // ****************************************
    logic       done_tgl_ff;
    logic       done_s;
    logic       done_prev_ff;
    logic [W-1:0] rx_raw_ff;
    logic       eng_order_ff;

    spcs_sync #(.W(1)) u_done_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (done_tgl_ff),
        .q     (done_s)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_prev_ff <= 1'b0;
        end else begin
            done_prev_ff <= done_s;
        end
    end
    assign done_seen = done_s ^ done_prev_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_word_ff <= '0;
        end else if (done_seen) begin
            rx_word_ff <= eng_order_ff ? rx_raw_ff : rev_bits(rx_raw_ff);
        end
    end

    // ****************************************
    // link clock domain
    // ****************************************
    logic [6:0] lk_s;
    logic       start_prev_ff;
    logic       eng_cke_ff;
    logic [W-1:0] sh_ff;
    logic       mosi_ff;
    logic       sel_n_ff;
    logic       sel_oe_ff;
    logic       bus_oe_ff;
    logic [1:0] samp_d_ff;
    logic [1:0] last_d_ff;

    spcs_sync #(.W(7)) u_link_sync (
        .clk   (link_clk),
        .rst_n (hresetn),
        .d     ({miso_i, start_tgl_ff, ctrl_ff}),
        .q     (lk_s)
    );

    wire miso_s    = lk_s[6];
    wire start_s   = lk_s[5];
    wire cfg_en    = lk_s[SPCS_CTRL_EN];
    wire cfg_order = lk_s[SPCS_CTRL_ORDER];
    wire cfg_selen = lk_s[SPCS_CTRL_SELEN];
    wire cfg_pol   = lk_s[SPCS_CTRL_POL];
    wire cfg_cke   = lk_s[SPCS_CTRL_EDGE];
    wire start_pulse = start_s ^ start_prev_ff;
    wire eng_go      = start_pulse & cfg_en;

    spcs_edge_if eif ();

    assign eif.start      = eng_go;
    assign eif.idle_level = ~cfg_pol;

    spcs_clkgen #(.W(W)) u_clkgen (
        .clk   (link_clk),
        .rst_n (hresetn),
        .eif   (eif)
    );

    // edge bit 0: capture on leading edge, 1: on trailing edge
    wire launch = eng_cke_ff ? eif.lead : eif.trail;
    wire sample = eng_cke_ff ? eif.trail : eif.lead;
    wire [W-1:0] load_word = cfg_order ? tx_word_ff : rev_bits(tx_word_ff);

    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            start_prev_ff <= 1'b0;
            done_tgl_ff   <= 1'b0;
        end else begin
            start_prev_ff <= start_s;
            if ((start_pulse && !cfg_en) || last_d_ff[1]) begin
                done_tgl_ff <= ~done_tgl_ff;
            end
        end
    end

    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            eng_cke_ff   <= 1'b0;
            eng_order_ff <= 1'b0;
            sh_ff        <= '0;
            mosi_ff      <= 1'b0;
        end else if (eng_go) begin
            eng_cke_ff   <= cfg_cke;
            eng_order_ff <= cfg_order;
            if (cfg_cke) begin
                sh_ff <= load_word;
            end else begin
                mosi_ff <= load_word[W-1];
                sh_ff   <= load_word << 1;
            end
        end else if (launch) begin
            mosi_ff <= sh_ff[W-1];
            sh_ff   <= sh_ff << 1;
        end
    end

    // miso is two link cycles late through its synchroniser: capture and completion follow it
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            samp_d_ff <= 2'h0;
            last_d_ff <= 2'h0;
        end else begin
            samp_d_ff <= {samp_d_ff[0], sample};
            last_d_ff <= {last_d_ff[0], eif.last};
        end
    end

    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            rx_raw_ff <= '0;
        end else if (samp_d_ff[1]) begin
            rx_raw_ff <= {rx_raw_ff[W-2:0], miso_s};
        end
    end

    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            sel_n_ff  <= 1'b1;
            sel_oe_ff <= 1'b0;
            bus_oe_ff <= 1'b0;
        end else begin
            // released half a period after the last edge, never with it
            sel_n_ff  <= ~(eng_go | eif.active);
            sel_oe_ff <= cfg_selen & cfg_en;
            bus_oe_ff <= cfg_en;
        end
    end

    assign sck_o            = eif.sck;
    assign mosi_o           = mosi_ff;
    assign bus_oe_o         = bus_oe_ff;
    assign select_line_n_o  = sel_n_ff;
    assign select_line_n_oe = sel_oe_ff;

    // ****************************************
    // assertions
    // ****************************************
    a_write_collision_flag_on_busy: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_data && busy_ff) |=> write_collision_flag_ff)
        else $error("collision flag not set by write during transfer");

    a_collide_keeps_word: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_data && busy_ff) |=> ($stable(tx_word_ff) && $stable(start_tgl_ff)))
        else $error("colliding write altered the transfer");

    a_write_collision_flag_sticky: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (write_collision_flag_ff && !wr_stat) |=> write_collision_flag_ff)
        else $error("collision flag cleared without software");

    a_tcf_on_done: assert property (
        @(posedge hclk) disable iff (!hresetn)
        done_seen |=> (tcf_ff && !busy_ff))
        else $error("complete flag not set at end of transfer");

    a_tcf_sticky: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (tcf_ff && !wr_stat) |=> tcf_ff)
        else $error("complete flag cleared without software");

    a_irq_follows: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(tcf_ff) |=> xfer_irq)
        else $error("interrupt request missing after completion");

    a_start_on_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        do_start |=> (busy_ff && (start_tgl_ff != $past(start_tgl_ff))))
        else $error("enabled write did not start a transfer");

    a_sck_idle_level: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        (!eif.active && !eng_go) ##1 !eif.active |-> (sck_o == !$past(cfg_pol)))
        else $error("serial clock idle level wrong");

    a_sel_floats: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        !cfg_selen |=> !select_line_n_oe)
        else $error("select pin driven while select enable is 0");

    a_capture_edge: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        (eif.active && (eng_cke_ff ? eif.lead : eif.trail)) |-> ##3 $stable(rx_raw_ff))
        else $error("data captured on the launch edge");

    a_first_bit_order: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        (eng_go && !cfg_cke) |=> (mosi_o == (eng_order_ff ? tx_word_ff[W-1] : tx_word_ff[0])))
        else $error("first bit out does not match bit order");

    a_frame_edges: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        eng_go |=> eif.active [*2])
        else $error("frame ended too early");

    c_collision: cover property (
        @(posedge hclk) disable iff (!hresetn) do_collide);

    c_lsb_done: cover property (
        @(posedge hclk) disable iff (!hresetn) done_seen && !eng_order_ff);

    c_trail_capture: cover property (
        @(posedge link_clk) disable iff (!hresetn) eif.last && eng_cke_ff);
endmodule : spcs_top

// ### testbench/spcs_slave_model.sv
`timescale 1ns/1ps
module spcs_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       idle_low,
    input  wire logic       cap_trail,
    input  wire logic       msb_first,
    input  wire logic [7:0] tx_word,
    output logic            miso,
    output logic [7:0]      rx_word
);
    logic [2:0] idx;
    logic [2:0] pos;
    int         n_bits;
    logic       lead;

    initial begin
        idx = 3'h0;
        n_bits = 0;
        rx_word = 8'h00;
    end

    // ****************************************
    // frame start: first bit ready before any edge
    // ****************************************
    always @(negedge sel_n) begin
        idx = 3'h0;
        n_bits = 0;
    end

    // ****************************************
    // capture on the chosen edge, launch on the other
    // ****************************************
    always @(sck) begin
        if (sel_n === 1'b0) begin
            lead = (sck == idle_low);
            if (lead != cap_trail) begin
                rx_word = msb_first ? {rx_word[6:0], mosi} : {mosi, rx_word[7:1]};
                n_bits++;
            end else if (n_bits > 0) begin
                idx = idx + 3'h1;
            end
        end
    end

    assign pos  = msb_first ? 3'h7 - idx : idx;
    // deselected: no pull, so show the inverse rather than a stale bit
    assign miso = sel_n ? ~tx_word[pos] : tx_word[pos];
endmodule : spcs_slave_model

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb
    import spcs_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        link_clk;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        sck_o;
    logic        mosi_o;
    logic        bus_oe_o;
    logic        miso;
    logic        sel_n_o;
    logic        sel_n_oe;
    logic        xfer_irq;
    logic        sel_line;
    logic        sck_line;
    logic        m_pol;
    logic        m_edge;
    logic        m_msb;
    logic [7:0]  s_tx;
    logic [7:0]  s_rx;
    logic [31:0] rd;
    logic [7:0]  w;
    logic [4:0]  ctrl;
    int          n_fail;
    int          checked;
    int          cyc;

    spcs_top #(.W(8)) i_spcs_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk),
        .sck_o(sck_o), .mosi_o(mosi_o), .bus_oe_o(bus_oe_o), .miso_i(miso),
        .select_line_n_o(sel_n_o), .select_line_n_oe(sel_n_oe), .xfer_irq(xfer_irq)
    );

    // select pin pulled up while floating
    assign sel_line = sel_n_oe ? sel_n_o : 1'b1;
    assign sck_line = bus_oe_o ? sck_o : ~m_pol;

    spcs_slave_model i_spcs_slave_model (
        .sck(sck_line), .mosi(mosi_o), .sel_n(sel_line), .idle_low(m_pol),
        .cap_trail(m_edge), .msb_first(m_msb), .tx_word(s_tx), .miso(miso), .rx_word(s_rx)
    );

    // ****************************************
    // clocks, timeout
    // ****************************************
    initial hclk = 1'b0;
    always #20 hclk = ~hclk;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end
    initial cyc = 0;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic wait_done(output logic [31:0] st);
        st = 32'h0;
        for (int i = 0; i < 200 && st[0] !== 1'b1; i++) bus(1'b0, SPCS_OFF_STAT, 32'h0, st);
    endtask : wait_done

    task automatic end_sim();
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        n_fail = 0;
        checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        m_pol = 1'b0;
        m_edge = 1'b0;
        m_msb = 1'b0;
        s_tx = 8'h00;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("sck idle", {31'h0, sck_o}, 32'h1);
        chk("sel oe", {31'h0, sel_n_oe}, 32'h0);
        chk("bus oe", {31'h0, bus_oe_o}, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        bus(1'b0, SPCS_OFF_CTRL, 32'h0, rd);
        chk("ctrl rst", rd, 32'h0);
        bus(1'b1, 8'h0c, 32'hffffffff, rd);
        bus(1'b0, 8'h0c, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, SPCS_OFF_DATA, 32'h5a, rd);
        repeat (60) @(posedge hclk);
        bus(1'b0, SPCS_OFF_STAT, 32'h0, rd);
        chk("disabled start", rd, 32'h0);
        for (int m = 0; m < 8; m++) begin
            ctrl = {m[2], m[1], 1'b1, m[0], 1'b1};
            m_msb <= m[0];
            m_pol <= m[1];
            m_edge <= m[2];
            s_tx <= 8'h4b ^ 8'(m * 17);
            w = 8'h1d + 8'(m * 37);
            bus(1'b1, SPCS_OFF_CTRL, {27'h0, ctrl}, rd);
            repeat (20) @(posedge hclk);
            chk("sck idle", {31'h0, sck_o}, {31'h0, ~ctrl[3]});
            chk("sel oe", {31'h0, sel_n_oe}, 32'h1);
            chk("bus oe", {31'h0, bus_oe_o}, 32'h1);
            bus(1'b1, SPCS_OFF_DATA, {24'h0, w}, rd);
            if (m == 3) begin
                bus(1'b1, SPCS_OFF_DATA, 32'hc3, rd);
                bus(1'b0, SPCS_OFF_STAT, 32'h0, rd);
                chk("collision", rd, 32'h6);
            end
            wait_done(rd);
            chk("status done", rd, (m == 3) ? 32'h3 : 32'h1);
            chk("irq", {31'h0, xfer_irq}, 32'h1);
            chk("slave rx", {24'h0, s_rx}, {24'h0, w});
            bus(1'b0, SPCS_OFF_DATA, 32'h0, rd);
            chk("rx data", rd, {24'h0, s_tx});
            chk("hresp", {31'h0, hresp}, 32'h0);
            chk("sck idle", {31'h0, sck_o}, {31'h0, ~ctrl[3]});
            bus(1'b1, SPCS_OFF_STAT, 32'h0, rd);
            bus(1'b0, SPCS_OFF_STAT, 32'h0, rd);
            chk("status clr", rd, 32'h0);
            chk("irq clr", {31'h0, xfer_irq}, 32'h0);
        end
        bus(1'b1, SPCS_OFF_CTRL, 32'h01, rd);
        repeat (20) @(posedge hclk);
        chk("sel float", {31'h0, sel_n_oe}, 32'h0);
        end_sim();
    end
endmodule : tb
